//--- core/compact_timer.v
// compact timer: 16-bit up counter, two comparators, compare output,
// timer/counter and edge-aligned pwm modes, APB register access.
// assumes count_clk_in is synchronous to pclk; pready is always high.
// assumes software stops the counter before changing mode or action.
// count bytes are read one at a time, so a 16-bit read may tear.
`timescale 1ns/1ps
`include "compact_timer_defs.vh"

module compact_timer
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        count_clk_in,
  output wire        timer_pin_out,
  output wire        timer_pin_oe_n,
  output wire        match_a_flag,
  output wire        match_p_flag
);

  // software registers
  // control bytes keep unimplemented bits at zero
  reg  [7:0]  ctrl0_r;
  reg  [7:0]  ctrl1_r;
  reg  [15:0] cmpa_r;
  reg  [7:0]  period_r;
  reg         flag_a_r;
  reg         flag_p_r;

  // timer state
  // one prescaler serves every divided count rate
  reg  [15:0] cnt_r;
  reg  [15:0] cnt_nxt;
  reg  [7:0]  pre_r;
  reg         on_d_r;
  reg         ext_d_r;
  reg         lvl_r;
  reg         lvl_nxt;
  reg         pin_r;
  reg         oe_n_r;

  // decoded fields
  // plain taps, no extra state behind them
  wire        pause;
  wire [2:0]  clksel;
  wire        cnt_on;
  wire [1:0]  mode;
  wire [1:0]  act;
  wire        init_lvl;
  wire        inv;
  wire        swap;
  wire        clrsel;

  // bus strobes
  // all combinational, valid only while psel is high
  wire        setup_ph;
  wire        wr_en;
  wire        addr_ok;
  wire        sts_wr;
  wire        clr_a;
  wire        clr_p;

  // tick and match terms
  // single-cycle terms, judged before the edge they act on
  reg         tick;
  wire        on_rise;
  wire        run;
  wire [15:0] inc;
  wire        hit_a;
  wire        hit_p;
  wire        is_pwm;
  wire        is_cmp;
  wire        clr_on_a;
  wire        clr_now;
  wire        set_a;
  wire        set_p;
  wire [16:0] duty17;
  wire        pwm_act;

  // field taps of the two control bytes
  assign pause    = ctrl0_r[`CT_PAUSE_BIT];
  assign clksel   = ctrl0_r[`CT_CLKSEL_HI:`CT_CLKSEL_LO];
  assign cnt_on   = ctrl0_r[`CT_ON_BIT];
  assign mode     = ctrl1_r[`CT_MODE_HI:`CT_MODE_LO];
  assign act      = ctrl1_r[`CT_ACT_HI:`CT_ACT_LO];
  assign init_lvl = ctrl1_r[`CT_INIT_BIT];
  assign inv      = ctrl1_r[`CT_INV_BIT];
  assign swap     = ctrl1_r[`CT_SWAP_BIT];
  assign clrsel   = ctrl1_r[`CT_CLRSEL_BIT];

  // APB handshake: zero wait states
  // unmapped slots answer with pslverr and drop writes
  assign pready   = 1'b1;
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign addr_ok  = (paddr == `CT_ADDR_CTRL0)   |
                    (paddr == `CT_ADDR_CTRL1)   |
                    (paddr == `CT_ADDR_CNT_LO)  |
                    (paddr == `CT_ADDR_CNT_HI)  |
                    (paddr == `CT_ADDR_CMPA_LO) |
                    (paddr == `CT_ADDR_CMPA_HI) |
                    (paddr == `CT_ADDR_PERIOD)  |
                    (paddr == `CT_ADDR_STATUS);
  assign pslverr  = psel & penable & ~addr_ok;

  // write-one-to-clear strobes of the status byte
  assign sts_wr   = wr_en & (paddr == `CT_ADDR_STATUS);
  assign clr_a    = sts_wr & pwdata[`CT_FLAG_A_BIT];
  assign clr_p    = sts_wr & pwdata[`CT_FLAG_P_BIT];

  // count clock select: prescaled pclk or external pin edge
  // prescaler free-runs, so the first tick after turn-on may be early
  always @*
  begin
    case (clksel)
      3'h0:    tick = (pre_r[1:0] == `CT_DIV4_MASK);
      3'h1:    tick = 1'b1;
      3'h2:    tick = (pre_r[3:0] == `CT_DIV16_MASK);
      3'h3:    tick = (pre_r[5:0] == `CT_DIV64_MASK);
      3'h4:    tick = (pre_r == `CT_DIV256_MASK);
      3'h5:    tick = (pre_r == `CT_DIV256_MASK);
      3'h6:    tick = count_clk_in & ~ext_d_r;
      3'h7:    tick = ~count_clk_in & ext_d_r;
      default: tick = 1'b0;
    endcase
  end

  // counter enable and edge of the on bit
  assign on_rise  = cnt_on & ~on_d_r;
  assign run      = cnt_on & ~pause & tick & ~on_rise;
  assign inc      = cnt_r + 16'h0001;

  // comparators look at the value the counter steps into
  // so the clear and the flag land on one edge
  assign hit_a    = run & (inc[15:0] == cmpa_r)
                    & (cmpa_r != `CT_RST_WORD);
  // P value zero only matches the wrap to zero, i.e. overflow
  assign hit_p    = run & (inc[15:0] == {period_r, 8'h00});

  // mode decode; undefined mode 01 counts like compare
  assign is_pwm   = (mode == `CT_MODE_PWM);
  assign is_cmp   = (mode == `CT_MODE_CMP);

  // pwm picks the clear source by swap, other modes by select
  // clear select is ignored while in pwm
  assign clr_on_a = is_pwm ? swap : clrsel;

  // clearing event of the selected comparator
  assign clr_now  = clr_on_a ? hit_a : hit_p;

  // flags: A always, P suppressed when A clears outside pwm
  assign set_a    = hit_a;
  assign set_p    = hit_p & (is_pwm | ~clrsel);

  // duty threshold in count clocks, 65536 for P zero
  // 17 bits so a full-length duty stays above every count
  assign duty17   = swap ?
                    ((period_r == `CT_RST_BYTE) ? 17'h10000
                                                : {1'b0, period_r, 8'h00})
                    : {1'b0, cmpa_r};
  // duty at or past period keeps count below it always
  assign pwm_act  = ({1'b0, cnt_nxt} < duty17);

  // next count value
  // turn-on zeroing outranks a tick in the same cycle
  always @*
  begin
    cnt_nxt = cnt_r;
    if (on_rise)
    begin
      cnt_nxt = `CT_RST_WORD;
    end
    else if (run)
    begin
      if (clr_now)
      begin
        cnt_nxt = `CT_RST_WORD;
      end
      else
      begin
        cnt_nxt = inc[15:0];
      end
    end
  end

  // next output level before polarity
  // pwm level follows the count; forced codes ignore it
  always @*
  begin
    lvl_nxt = lvl_r;
    if (is_pwm)
    begin
      case (act)
        `CT_PWM_INACT: lvl_nxt = ~init_lvl;
        `CT_PWM_ACT:   lvl_nxt = init_lvl;
        `CT_PWM_WAVE:  lvl_nxt = pwm_act ? init_lvl : ~init_lvl;
        default:       lvl_nxt = lvl_r;
      endcase
    end
    else if (on_rise)
    begin
      lvl_nxt = init_lvl;
    end
    else if (is_cmp & set_a)
    begin
      case (act)
        `CT_CMP_NONE: lvl_nxt = lvl_r;
        `CT_CMP_LOW:  lvl_nxt = 1'b0;
        `CT_CMP_HIGH: lvl_nxt = 1'b1;
        `CT_CMP_TOG:  lvl_nxt = ~lvl_r;
        default:      lvl_nxt = lvl_r;
      endcase
    end
  end

  // prescaler, edge history and counter
  // on-bit history makes the turn-on a one-cycle event
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_r   <= `CT_RST_BYTE;
      ext_d_r <= 1'b0;
      on_d_r  <= 1'b0;
      cnt_r   <= `CT_RST_WORD;
    end
    else
    begin
      pre_r   <= pre_r + 8'h01;
      ext_d_r <= count_clk_in;
      on_d_r  <= cnt_on;
      cnt_r   <= cnt_nxt;
    end
  end

  // output level and pin drive
  // pin enable follows the mode one cycle after a write
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl_r  <= 1'b0;
      pin_r  <= 1'b0;
      oe_n_r <= 1'b1;
    end
    else
    begin
      lvl_r  <= lvl_nxt;
      pin_r  <= lvl_nxt ^ inv;
      // pin released in timer/counter and undefined modes
      oe_n_r <= ~(is_cmp | is_pwm);
    end
  end

  // pin outputs straight from flops
  assign timer_pin_out  = pin_r;
  assign timer_pin_oe_n = oe_n_r;

  // control and compare registers
  // count bytes and status fall through untouched here
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl0_r  <= `CT_RST_BYTE;
      ctrl1_r  <= `CT_RST_BYTE;
      cmpa_r   <= `CT_RST_WORD;
      period_r <= `CT_RST_BYTE;
    end
    else if (wr_en)
    begin
      case (paddr)
        // low three bits unimplemented
        `CT_ADDR_CTRL0:   ctrl0_r <= {pwdata[7:3], 3'h0};
        `CT_ADDR_CTRL1:   ctrl1_r <= pwdata[7:0];
        `CT_ADDR_CMPA_LO: cmpa_r[7:0] <= pwdata[7:0];
        `CT_ADDR_CMPA_HI: cmpa_r[15:8] <= pwdata[7:0];
        `CT_ADDR_PERIOD:  period_r <= pwdata[7:0];
        default:          ctrl0_r <= ctrl0_r;
      endcase
    end
  end

  // match flags: hardware set beats software clear
  // a clear racing a match loses, so no event is missed
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end
    else
    begin
      if (set_a)
      begin
        flag_a_r <= 1'b1;
      end
      else if (clr_a)
      begin
        flag_a_r <= 1'b0;
      end
      if (set_p)
      begin
        flag_p_r <= 1'b1;
      end
      else if (clr_p)
      begin
        flag_p_r <= 1'b0;
      end
    end
  end

  // flag outputs mirror the status bits
  assign match_a_flag = flag_a_r;
  assign match_p_flag = flag_p_r;

  // read data captured in the setup cycle, shown in access
  // capturing early keeps the access phase free of wait states
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (setup_ph)
    begin
      case (paddr)
        `CT_ADDR_CTRL0:   prdata <= {24'h000000, ctrl0_r};
        `CT_ADDR_CTRL1:   prdata <= {24'h000000, ctrl1_r};
        `CT_ADDR_CNT_LO:  prdata <= {24'h000000, cnt_r[7:0]};
        `CT_ADDR_CNT_HI:  prdata <= {24'h000000, cnt_r[15:8]};
        `CT_ADDR_CMPA_LO: prdata <= {24'h000000, cmpa_r[7:0]};
        `CT_ADDR_CMPA_HI: prdata <= {24'h000000, cmpa_r[15:8]};
        `CT_ADDR_PERIOD:  prdata <= {24'h000000, period_r};
        `CT_ADDR_STATUS:  prdata <= {30'h0, flag_p_r, flag_a_r};
        default:          prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // compact_timer

//--- core/compact_timer_defs.vh
// constants for the compact timer: register map, field positions,
// reset values, mode and action codes, prescaler divides.
// assumes an APB slave with 8-bit byte address and 32-bit data.
`ifndef COMPACT_TIMER_DEFS_VH
`define COMPACT_TIMER_DEFS_VH

// register byte addresses
`define CT_ADDR_CTRL0      8'h00
`define CT_ADDR_CTRL1      8'h04
`define CT_ADDR_CNT_LO     8'h08
`define CT_ADDR_CNT_HI     8'h0C
`define CT_ADDR_CMPA_LO    8'h10
`define CT_ADDR_CMPA_HI    8'h14
`define CT_ADDR_PERIOD     8'h18
`define CT_ADDR_STATUS     8'h1C

// control zero fields
`define CT_PAUSE_BIT       7
`define CT_CLKSEL_HI       6
`define CT_CLKSEL_LO       4
`define CT_ON_BIT          3

// control one fields
`define CT_MODE_HI         7
`define CT_MODE_LO         6
`define CT_ACT_HI          5
`define CT_ACT_LO          4
`define CT_INIT_BIT        3
`define CT_INV_BIT         2
`define CT_SWAP_BIT        1
`define CT_CLRSEL_BIT      0

// status fields, write one to clear
`define CT_FLAG_A_BIT      0
`define CT_FLAG_P_BIT      1

// reset values
`define CT_RST_BYTE        8'h00
`define CT_RST_WORD        16'h0000

// mode codes
`define CT_MODE_CMP        2'h0
`define CT_MODE_PWM        2'h2
`define CT_MODE_TMR        2'h3

// output action codes, compare mode
`define CT_CMP_NONE        2'h0
`define CT_CMP_LOW         2'h1
`define CT_CMP_HIGH        2'h2
`define CT_CMP_TOG         2'h3

// output action codes, pwm mode
`define CT_PWM_INACT       2'h0
`define CT_PWM_ACT         2'h1
`define CT_PWM_WAVE        2'h2

// prescaler terminal masks (divide by 4, 16, 64, 256)
`define CT_DIV4_MASK       2'h3
`define CT_DIV16_MASK      4'hF
`define CT_DIV64_MASK      6'h3F
`define CT_DIV256_MASK     8'hFF

`endif

//--- dv/compact_timer_properties.sv
// port assertions for the compact timer
// assumes binding to every compact_timer instance
`timescale 1ns/1ps
module compact_timer_properties
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        count_clk_in,
  input wire        timer_pin_out,
  input wire        timer_pin_oe_n,
  input wire        match_a_flag,
  input wire        match_p_flag
);
  reg  [7:0] c0_r;
  reg  [7:0] c1_r;
  reg  [1:0] st_r;
  wire       wr = psel & penable & pwrite & pready;
  wire       lvl = c1_r[3] ^ c1_r[2];
  // control shadows and a settle count after control writes
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      c0_r <= 8'h00;
      c1_r <= 8'h00;
      st_r <= 2'h0;
    end
    else
    begin
      if (wr && paddr == 8'h00)
        c0_r <= pwdata[7:0];
      if (wr && paddr == 8'h04)
        c1_r <= pwdata[7:0];
      if (wr && paddr < 8'h08)
        st_r <= 2'h0;
      else if (st_r != 2'h3)
        st_r <= st_r + 2'h1;
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_upper_zero: assert property (psel && penable |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_err_decode: assert property (psel && penable && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > 8'h1C)) else $error("bad slave error");
  a_pin_oe: assert property (st_r == 2'h3 |-> timer_pin_oe_n == c1_r[6])
    else $error("pin enable wrong for mode");
  a_no_pflag: assert property (st_r == 2'h3 && c1_r[0] && c1_r[7:6] != 2'h2
    |-> !$rose(match_p_flag)) else $error("p flag with a clearing");
  a_pin_none: assert property (st_r == 2'h3 && c0_r[3] && c1_r[7:4] == 4'h0
    |=> $stable(timer_pin_out)) else $error("pin moved with no action");
  a_pin_init: assert property (wr && paddr == 8'h00 && pwdata[3] && !c0_r[3]
    && c1_r[7:4] == 4'h0 |-> ##2 timer_pin_out == lvl) else $error("pin not initial");
  a_flag_clear: assert property (wr && paddr == 8'h1C && pwdata[1:0] == 2'h3 && !c0_r[3]
    |=> ##1 !match_a_flag && !match_p_flag) else $error("flags not cleared");
  a_pwm_force: assert property (st_r == 2'h3 && c0_r[3] && c1_r[7:5] == 3'h4
    |-> timer_pin_out == (lvl ^ ~c1_r[4])) else $error("forced level wrong");
endmodule // compact_timer_properties
bind compact_timer compact_timer_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_clk_in(count_clk_in),
  .timer_pin_out(timer_pin_out), .timer_pin_oe_n(timer_pin_oe_n),
  .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

//--- dv/testbench.sv
// self-checking bench for the compact timer over APB
// assumes the design header is on the include path
`timescale 1ns/1ps
`include "compact_timer_defs.vh"
module testbench;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic        cclk = 0;
  logic        cprev = 0;
  logic        ext_on = 0;
  integer      ext_n = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, pin, oe_n, fa, fp;
  integer      err_count = 0;
  integer      checks = 0;
  integer      seed = 32'hef96;
  integer      k, i, hi;
  logic [32:0] expq[$];
  logic [15:0] av;
  logic [7:0]  pv;
  logic [7:0]  pc [7] = '{8'hA9, 8'hA9, 8'hAB, 8'hAF, 8'hA1, 8'h89, 8'h99};
  logic [15:0] pa [7] = '{16'h40, 16'h200, 16'h300, 16'h300, 16'h40, 16'h40, 16'h40};
  int          pn [7] = '{256, 256, 768, 768, 256, 256, 256};
  int          pe [7] = '{64, 256, 256, 512, 192, 0, 256};
  // bus clock and a random external count input
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) cclk <= $random(seed);
  // rising edges of the count input seen while counting is expected
  always @(posedge pclk)
  begin
    cprev <= cclk;
    if (ext_on && cclk && !cprev)
      ext_n <= ext_n + 1;
  end
  compact_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_clk_in(cclk), .timer_pin_out(pin), .timer_pin_oe_n(oe_n),
    .match_a_flag(fa), .match_p_flag(fp));
  task chk(input logic [32:0] s, input logic [32:0] e);
    checks = checks + 1;
    if (s !== e)
    begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one transfer: setup, then access until pready
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k = k + 1;
    end
    while (pready !== 1'b1 && k < 50);
    if (k == 50)
    begin
      err_count = err_count + 1;
      complete_run;
    end
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic se);
    expq.push_back({se, 24'h0, e});
    apb(0, a, 8'h00);
  endtask
  task cfg(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p);
    apb(1, `CT_ADDR_CTRL0, 8'h00);
    apb(1, `CT_ADDR_CMPA_LO, a[7:0]);
    apb(1, `CT_ADDR_CMPA_HI, a[15:8]);
    apb(1, `CT_ADDR_PERIOD, p);
    apb(1, `CT_ADDR_CTRL1, c1);
    apb(1, `CT_ADDR_STATUS, 8'h03);
    apb(1, `CT_ADDR_CTRL0, 8'h18);
  endtask
  task meas(input int n, input int e);
    hi = 0;
    repeat (n)
    begin
      @(posedge pclk);
      hi = hi + (pin === 1'b1);
    end
    chk(33'(hi), 33'(e));
  endtask
  // read results compared against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, expq.pop_front());
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    // reset values, unmapped slot refused
    for (i = 0; i < 9; i = i + 1)
      rd(8'(i * 4), 8'h00, i == 8);
    av = $random(seed);
    pv = $random(seed);
    apb(1, `CT_ADDR_CMPA_LO, av[7:0]);
    apb(1, `CT_ADDR_CMPA_HI, av[15:8]);
    apb(1, `CT_ADDR_PERIOD, pv);
    apb(1, `CT_ADDR_CNT_LO, 8'h5A);
    apb(1, `CT_ADDR_CNT_HI, 8'hA5);
    rd(`CT_ADDR_CMPA_LO, av[7:0], 0);
    rd(`CT_ADDR_CMPA_HI, av[15:8], 0);
    rd(`CT_ADDR_PERIOD, pv, 0);
    rd(`CT_ADDR_CNT_HI, 8'h00, 0);
    // p clearing with zero a value, then a clearing past p
    cfg(8'h00, 16'h0000, 8'h01);
    repeat (600) @(posedge pclk);
    rd(`CT_ADDR_STATUS, 8'h02, 0);
    chk({fp, fa}, 2'h2);
    rd(`CT_ADDR_CNT_HI, 8'h00, 0);
    cfg(8'h01, 16'h0180, 8'h01);
    repeat (600) @(posedge pclk);
    rd(`CT_ADDR_STATUS, 8'h01, 0);
    chk({fp, fa}, 2'h1);
    // pin actions on compare a match
    for (i = 0; i < 4; i = i + 1)
    begin
      cfg({2'h0, 2'(i), 4'h1}, 16'h0010, 8'h00);
      repeat (40) @(posedge pclk);
      meas(32, i == 2 ? 32 : i == 3 ? 16 : 0);
      chk(oe_n, 0);
    end
    apb(1, `CT_ADDR_CTRL1, 8'h11);
    repeat (20) @(posedge pclk);
    chk(pin, 0);
    cfg(8'h09, 16'h0010, 8'h00);
    repeat (2) @(posedge pclk);
    meas(32, 32);
    cfg(8'hC1, 16'h0010, 8'h00);
    repeat (40) @(posedge pclk);
    chk(oe_n, 1);
    rd(`CT_ADDR_STATUS, 8'h01, 0);
    // pause at turn-on holds a zero count
    apb(1, `CT_ADDR_CTRL0, 8'h00);
    apb(1, `CT_ADDR_CTRL0, 8'h98);
    repeat (50) @(posedge pclk);
    rd(`CT_ADDR_CNT_LO, 8'h00, 0);
    // external rising edges counted in timer mode, held when off
    apb(1, `CT_ADDR_CTRL0, 8'h00);
    apb(1, `CT_ADDR_CMPA_LO, 8'h00);
    apb(1, `CT_ADDR_CMPA_HI, 8'h00);
    apb(1, `CT_ADDR_CTRL0, 8'h68);
    @(posedge pclk);
    ext_on <= 1;
    repeat (200) @(posedge pclk);
    apb(1, `CT_ADDR_CTRL0, 8'h60);
    ext_on <= 0;
    @(posedge pclk);
    rd(`CT_ADDR_CNT_LO, 8'(ext_n), 0);
    rd(`CT_ADDR_CNT_HI, 8'h00, 0);
    // pwm period, duty, swap, polarity and forced levels
    for (i = 0; i < 7; i = i + 1)
    begin
      cfg(pc[i], pa[i], 8'h01);
      repeat (800) @(posedge pclk);
      meas(pn[i], pe[i]);
      chk(oe_n, 0);
    end
    complete_run;
  end
endmodule // testbench
